/* File: hw/wel_protect_core.sv */
// Write-enable latch, register protection and fail-flag clear logic.
// Summary of operation
// - Lock set, pin high: writes need latch.
// - Lock set, pin low: writes rejected, regWriteRejected pulses.
// - Hardware lock freezes block-protect bits.
// - Lock engages last of both, pin releases.
// - Otherwise lock, range, config writable with latch.
// - Status register resets to all zeros.
// - Quad enable disables hardware register lock.
// - Opcode 06h sets the latch.
// - Set-latch runs only on eight-bit frame.
// - Opcode 04h clears latch, blocks modifying commands.
// - Clear-latch ignored while busy.
// - Clear-latch runs only on eight-bit frame.
// - Four-bit mode takes instructions per nibble.
// - Clear-status resets erase and program fail.
// - Clear-status ignores and keeps the latch.
// - Clear-status accepted while busy; fails hold busy.
// - 30h optional clear, 82h always clears.
// - Eight data bits status; sixteen adds config.
// - Finished register write clears the latch.
`timescale 1ns/100ps
module latch_protect_core #(
   parameter int SECTOR_W = 7
) (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                clkEn,
   input  wire logic                sclk,
   input  wire logic                csB,
   input  wire logic [3:0]          dataIn,
   input  wire logic                legacyClearEn,
   input  wire logic                coreBusy,
   input  wire logic                eraseFailSet,
   input  wire logic                programFailSet,
   input  wire logic                peReq,
   input  wire logic                peBulk,
   input  wire logic [SECTOR_W-1:0] peSector,
   output logic [7:0]               statusOne,
   output logic [7:0]               configOne,
   output logic                     hwProtected,
   output logic                     regWriteRejected,
   output logic                     resumeReq,
   output logic                     peGrant,
   output logic                     peDeny
);
   import latch_protect_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Elaboration check: the lowest range level must map onto whole sectors.
   if (SECTOR_W < BP_LEVELS)
   begin : gSectorCheck
      $error("SECTOR_W too small for the block-protect encoding");
   end

   logic [EDGE_W-1:0] edgeCount;    // Edges of the last frame.
   logic [WORD_W-1:0] serialWord;   // Single-line bits of the frame.
   logic [WORD_W-1:0] nibbleWord;   // Four-line bits of the frame.
   logic              csHigh;       // Filtered chip select level.
   logic              wpHigh;       // Filtered protect pin level.
   logic              csHighPrev_q; // Previous filtered chip select.
   logic              latch_q;      // Write-enable latch.
   logic              lockBit_q;    // Register write lock bit.
   logic [2:0]        bp_q;         // Protect range bits.
   logic              eFail_q;      // Erase fail flag.
   logic              pFail_q;      // Program fail flag.
   logic              busyRw_q;     // Self-timed register write running.
   logic [TIMER_W-1:0] timer_q;     // Cycles left in the register write.
   logic [7:0]        srData_q;     // Status byte waiting to commit.
   logic [7:0]        crData_q;     // Config byte waiting to commit.
   logic              crPend_q;     // Config byte is part of the write.

   ////////////////////////////////////////////////////////////////////
   // The link side runs on the host's serial clock.
   link_capture uLink (
      .sclk       (sclk),
      .rst_b      (rst_b),
      .csB        (csB),
      .dataIn     (dataIn),
      .edgeCount  (edgeCount),
      .serialWord (serialWord),
      .nibbleWord (nibbleWord)
   );

   // Chip select enters clk through the filtered synchroniser.
   pin_filter #(.RESET_VAL(PIN_IDLE)) uCsSync (
      .clk   (clk),
      .rst_b (rst_b),
      .clkEn (clkEn),
      .pinIn (csB),
      .level (csHigh)
   );

   // The protect pin shares data line two with four-bit transfers.
   pin_filter #(.RESET_VAL(PIN_IDLE)) uWpSync (
      .clk   (clk),
      .rst_b (rst_b),
      .clkEn (clkEn),
      .pinIn (dataIn[2]),
      .level (wpHigh)
   );

   ////////////////////////////////////////////////////////////////////
   // Frame end. The link words are sampled only after chip select has
   // settled high, by which time the serial clock has stopped and the
   // words are static; the host must keep deselect longer than five
   // clk periods so the next frame does not overwrite them first.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         csHighPrev_q <= PIN_IDLE;
      else if (clkEn)
         csHighPrev_q <= csHigh;
   end

   logic              frameEnd;     // One cycle after deselect settles.
   logic              quadMode;     // Four-bit instruction mode.
   logic [7:0]        bitsSeen;     // Bits in the finished frame.
   logic [WORD_W-1:0] word;         // Frame bits in the current mode.
   logic              is8;          // Instruction-only frame.
   logic              is16;         // Instruction plus one byte.
   logic              is24;         // Instruction plus two bytes.
   logic [7:0]        op8;          // Opcode of an eight-bit frame.
   logic [7:0]        opRw;         // Opcode of a longer frame.
   logic              busy;         // Busy flag as software sees it.
   logic              hwLock;       // Registers hardware protected.

   assign frameEnd = clkEn && csHigh && !csHighPrev_q;
   assign quadMode = configOne[QUAD_BIT];
   // Four lines carry four bits per edge in four-bit mode.
   assign bitsSeen = quadMode ? {edgeCount, 2'b00} : {2'b00, edgeCount};
   assign word     = quadMode ? nibbleWord : serialWord;
   // Any other count of bits at deselect discards the frame.
   assign is8  = (bitsSeen == 8'(FRAME_CMD_BITS));
   assign is16 = (bitsSeen == 8'(FRAME_SR_BITS));
   assign is24 = (bitsSeen == 8'(FRAME_CR_BITS));
   assign op8  = word[7:0];
   assign opRw = is16 ? word[15:8] : word[23:16];

   // Fail flags keep the part busy until cleared.
   assign busy = coreBusy || busyRw_q || eFail_q || pFail_q;

   // Pure level: whichever of lock bit and low pin comes last engages
   // it, and only the pin going high releases it. In quad mode the pin
   // is a data line and the lock never applies.
   assign hwLock = lockBit_q && !wpHigh && !quadMode;

   ////////////////////////////////////////////////////////////////////
   // Command decode.
   logic setLatchHit;     // Set-latch frame.
   logic clearLatchHit;   // Clear-latch frame, not busy.
   logic clearFailHit;    // Clear-status frame.
   logic regWrHit;        // Register write frame of valid length.
   logic regWrOk;         // Register write accepted.
   logic commit;          // Last cycle of the self-timed write.

   assign setLatchHit = frameEnd && is8 && (op8 == OP_SET_LATCH);
   assign clearLatchHit = frameEnd && is8 && (op8 == OP_CLEAR_LATCH)
                          && !busy;
   assign clearFailHit = frameEnd && is8 && ((op8 == OP_CLEAR_FAIL_ALT)
                         || (op8 == OP_CLEAR_FAIL_LEGACY && legacyClearEn));
   assign regWrHit = frameEnd && (is16 || is24) && (opRw == OP_REG_WRITE);
   // The latch must already be set, and the hardware lock must be off.
   assign regWrOk = regWrHit && latch_q && !busy && !hwLock;
   assign commit  = busyRw_q && clkEn && (timer_q == TIMER_W'(1));

   // With the legacy code disabled, 30h becomes a resume request.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         resumeReq <= 1'b0;
      else if (clkEn)
         resumeReq <= frameEnd && is8 && (op8 == OP_CLEAR_FAIL_LEGACY)
                      && !legacyClearEn;
   end

   // A refused register write raises only this pulse, never a fail flag.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         regWriteRejected <= 1'b0;
      else if (clkEn)
         regWriteRejected <= regWrHit && !regWrOk;
   end

   ////////////////////////////////////////////////////////////////////
   // Write-enable latch. A set in the same cycle as a clear wins, so a
   // set-latch frame is never lost against a finishing write.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         latch_q <= 1'b0;
      else if (setLatchHit)
         latch_q <= 1'b1;
      else if (clearLatchHit || commit)
         latch_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Self-timed register write: capture bytes, count, then commit.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         busyRw_q <= 1'b0;
         timer_q  <= '0;
         srData_q <= STATUS_RESET;
         crData_q <= CONFIG_RESET;
         crPend_q <= 1'b0;
      end
      else if (regWrOk)
      begin
         busyRw_q <= 1'b1;
         timer_q  <= TIMER_W'(REG_WRITE_CYCLES);
         srData_q <= is16 ? word[7:0] : word[15:8];
         crData_q <= word[7:0];
         crPend_q <= is24;
      end
      else if (busyRw_q && clkEn)
      begin
         timer_q <= timer_q - TIMER_W'(1);
         if (commit)
            busyRw_q <= 1'b0;
      end
   end

   // Lock and range bits change only through an accepted write, so a
   // hardware lock keeps the protected range frozen.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lockBit_q <= STATUS_RESET[LOCK_BIT];
         bp_q      <= BP_RESET;
      end
      else if (commit)
      begin
         lockBit_q <= srData_q[LOCK_BIT];
         bp_q      <= srData_q[BP_LSB +: 3];
      end
   end

   // Config byte is written only by the sixteen-data-bit form.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         configOne <= CONFIG_RESET;
      else if (commit && crPend_q)
         configOne <= crData_q;
   end

   ////////////////////////////////////////////////////////////////////
   // Fail flags. A fresh failure in the clear cycle survives the clear.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         eFail_q <= 1'b0;
         pFail_q <= 1'b0;
      end
      else if (clkEn)
      begin
         eFail_q <= eraseFailSet || (eFail_q && !clearFailHit);
         pFail_q <= programFailSet || (pFail_q && !clearFailHit);
      end
   end

   // Status image is rebuilt each cycle from its sources.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         statusOne   <= STATUS_RESET;
         hwProtected <= 1'b0;
      end
      else if (clkEn)
      begin
         statusOne[BUSY_BIT]        <= busy;
         statusOne[LATCH_BIT]       <= latch_q;
         statusOne[BP_LSB +: 3]     <= bp_q;
         statusOne[E_FAIL_BIT]      <= eFail_q;
         statusOne[P_FAIL_BIT]      <= pFail_q;
         statusOne[LOCK_BIT]        <= lockBit_q;
         hwProtected                <= hwLock;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Program and erase gate. Levels 1..7 protect 1/64 up to all of the
   // array, counted down from the top sector.
   function automatic logic inRange(input logic [2:0]          bp,
                                    input logic [SECTOR_W-1:0] s);
      logic [SECTOR_W:0] count;
      count = '0;
      if (bp != 3'h0)
         count = (SECTOR_W+1)'(1) << (SECTOR_W - BP_LEVELS + int'(bp));
      return {1'b0, s} >= ((SECTOR_W+1)'(1) << SECTOR_W) - count;
   endfunction

   logic peProt;   // Request touches the protected range.
   assign peProt = peBulk ? (bp_q != 3'h0) : inRange(bp_q, peSector);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         peGrant <= 1'b0;
         peDeny  <= 1'b0;
      end
      else if (clkEn)
      begin
         peGrant <= peReq && !peProt && latch_q && !busy;
         peDeny  <= peReq && (peProt || !latch_q || busy);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   latchSet_a: assert property (setLatchHit |=> latch_q)
      else $error("set-latch frame did not set the latch");
   latchClear_a: assert property (clearLatchHit && !setLatchHit |=> !latch_q)
      else $error("clear-latch frame left the latch set");
   clearBusy_a: assert property (frameEnd && is8 && op8 == OP_CLEAR_LATCH
      && busy && latch_q && !commit |=> latch_q)
      else $error("clear-latch acted while busy");
   hwReject_a: assert property (regWrHit && hwLock |=> regWriteRejected
      && !busyRw_q)
      else $error("locked register write was not rejected");
   // The flags drop one edge after the clear; the status image one later.
   failClear_a: assert property (clearFailHit && !eraseFailSet && !programFailSet
      |=> (!eFail_q && !pFail_q) ##1 (!statusOne[E_FAIL_BIT] && !statusOne[P_FAIL_BIT]))
      else $error("clear-status left a fail flag");
   failKeepsLatch_a: assert property (clearFailHit && !commit |=> $stable(latch_q))
      else $error("clear-status changed the latch");
   commitLatch_a: assert property (commit && !setLatchHit |=> !latch_q)
      else $error("finished register write kept the latch");
   rwBusy_a: assert property (regWrOk |=> busyRw_q [*8])
      else $error("register write ended too soon");
   quadLock_a: assert property (quadMode && clkEn |=> !hwProtected)
      else $error("hardware lock active in quad mode");
   peDeny_a: assert property (peReq && clkEn && peProt |=> peDeny
      && !peGrant)
      else $error("protected program or erase was granted");
   shortFrame_a: assert property (frameEnd && !is8 && !is16 && !is24
      && !commit |=> $stable(latch_q))
      else $error("badly framed command changed the latch");
endmodule

/* File: hw/wel_protect_pkg.sv */
// Constants shared by the write-enable and register-protect command logic.
package latch_protect_pkg;

   // Instruction codes decoded at the end of a frame.
   localparam logic [7:0] OP_SET_LATCH         = 8'h06;
   localparam logic [7:0] OP_CLEAR_LATCH       = 8'h04;
   localparam logic [7:0] OP_CLEAR_FAIL_LEGACY = 8'h30;
   localparam logic [7:0] OP_CLEAR_FAIL_ALT    = 8'h82;
   localparam logic [7:0] OP_REG_WRITE         = 8'h01;

   // Field positions in volatile status one and volatile config one.
   localparam int BUSY_BIT   = 0;
   localparam int LATCH_BIT  = 1;
   localparam int BP_LSB     = 2;
   localparam int E_FAIL_BIT = 5;
   localparam int P_FAIL_BIT = 6;
   localparam int LOCK_BIT   = 7;
   localparam int QUAD_BIT   = 1;

   // Values after reset.
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [2:0] BP_RESET     = 3'h0;
   localparam logic       PIN_IDLE     = 1'b1;

   // Frame lengths in bits that select what a frame means.
   localparam int FRAME_CMD_BITS = 8;
   localparam int FRAME_SR_BITS  = 16;
   localparam int FRAME_CR_BITS  = 24;
   localparam int EDGE_W         = 6;
   localparam int WORD_W         = 24;

   // Block-protect encoding: seven nonzero levels, top-aligned.
   localparam int BP_LEVELS = 7;

   // Self-timed register write duration.
   localparam int CLK_PERIOD_NS     = 8;
   localparam int REG_WRITE_TIME_NS = 200;
   localparam int REG_WRITE_CYCLES  =
      (REG_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 8;

endpackage

/* File: hw/pin_filter.sv */
// Three-stage synchroniser with agreement filter for pins entering clk.
`timescale 1ns/100ps
module pin_filter #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic clkEn,
   input  wire logic pinIn,
   output logic      level
);
   import latch_protect_pkg::*;

   logic stage1_q;   // Metastable stage, read only by stage2_q.
   logic stage2_q;   // Second stage.
   logic stage3_q;   // Third stage, compared with the second.

   ////////////////////////////////////////////////////////////////////
   // The chain shifts only while the clock enable is high.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage1_q <= RESET_VAL;
         stage2_q <= RESET_VAL;
         stage3_q <= RESET_VAL;
      end
      else if (clkEn)
      begin
         stage1_q <= pinIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   // A change is believed only once two settled stages agree.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         level <= RESET_VAL;
      else if (clkEn && (stage2_q == stage3_q))
         level <= stage3_q;
   end
endmodule

/* File: hw/link_capture.sv */
// Serial-clock front end that counts edges and shifts in each frame.
`timescale 1ns/100ps
module link_capture (
   input  wire logic                               sclk,
   input  wire logic                               rst_b,
   input  wire logic                               csB,
   input  wire logic [3:0]                         dataIn,
   output logic [latch_protect_pkg::EDGE_W-1:0]    edgeCount,
   output logic [latch_protect_pkg::WORD_W-1:0]    serialWord,
   output logic [latch_protect_pkg::WORD_W-1:0]    nibbleWord
);
   import latch_protect_pkg::*;

   logic inFrame_q;   // Low until the first edge of a frame.

   ////////////////////////////////////////////////////////////////////
   // The serial clock stops between frames, so the frame flag is
   // cleared by chip select itself rather than by a clock edge.
   always_ff @(posedge sclk or posedge csB or negedge rst_b)
   begin
      if (!rst_b)
         inFrame_q <= 1'b0;
      else if (csB)
         inFrame_q <= 1'b0;
      else
         inFrame_q <= 1'b1;
   end

   // Edge counter saturates so long frames never wrap to a valid length.
   always_ff @(posedge sclk or negedge rst_b)
   begin
      if (!rst_b)
         edgeCount <= '0;
      else if (!inFrame_q)
         edgeCount <= EDGE_W'(1);
      else if (edgeCount != '1)
         edgeCount <= edgeCount + EDGE_W'(1);
   end

   // Both views are kept; the clk side picks one by the mode bit, which
   // avoids carrying the mode across into this stoppable domain.
   always_ff @(posedge sclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         serialWord <= '0;
         nibbleWord <= '0;
      end
      else
      begin
         serialWord <= {serialWord[WORD_W-2:0], dataIn[0]};
         nibbleWord <= {nibbleWord[WORD_W-5:0], dataIn};
      end
   end
endmodule

/* File: sim/host_model.sv */
// Host serial controller model that frames commands for the protect logic.
`timescale 1ns/100ps
module host_model (
   output logic       sclk,
   output logic       csB,
   output logic [3:0] dataIn,
   input  wire logic  wpLevel
);
   ////////////////////////////////////////////////////////////////////////////
   // Deselected at start, clock parked low as in mode 0.
   initial
   begin
      sclk = 1'b0;
      csB = 1'b1;
      dataIn = {1'b1, wpLevel, 2'b10};
   end

   // Between frames the protect line follows the bench level.
   always @(wpLevel or csB)
      if (csB)
         dataIn[2] = wpLevel;

   ////////////////////////////////////////////////////////////////////////////
   // Sends the low nBits of word, first bit first, 30 ns per link clock.
   // Unused lines toggle, so a stale value can never pass for data.
   task automatic send(input logic [23:0] word, input int nBits, input bit quad);
      int step;
      step = quad ? 4 : 1;
      csB = 1'b0;
      for (int i = nBits - step; i >= 0; i -= step)
      begin
         #5;
         if (quad)
            dataIn = word[i +: 4];
         else
            dataIn = {~dataIn[3], wpLevel, ~dataIn[1], word[i]};
         #10 sclk = 1'b1;
         #15 sclk = 1'b0;
      end
      // The frame ends right after its last bit, as the framing asks.
      #15 csB = 1'b1;
      dataIn = {~dataIn[3], wpLevel, ~dataIn[1], ~dataIn[0]};
      #100;
   endtask
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the write-enable and register-protect logic.
`timescale 1ns/100ps
module tb;
   import latch_protect_pkg::*;
   logic       clk, rst_b, legacyClearEn, coreBusy, eraseFailSet, programFailSet;
   logic       peReq, peBulk, wpLevel, sclk, csB;
   logic [6:0] peSector;
   logic [3:0] dataIn;
   logic [7:0] statusOne, configOne;
   logic       hwProtected, regWriteRejected, resumeReq, peGrant, peDeny;
   logic [3:0] seen;       // Sticky record of the one-cycle answer pulses.
   int         mismatches, checkCount, cycles;

   ////////////////////////////////////////////////////////////////////////////
   latch_protect_core u_latch_protect_core (.clk(clk), .rst_b(rst_b), .clkEn(1'b1),
      .sclk(sclk), .csB(csB), .dataIn(dataIn), .legacyClearEn(legacyClearEn),
      .coreBusy(coreBusy), .eraseFailSet(eraseFailSet), .programFailSet(programFailSet),
      .peReq(peReq), .peBulk(peBulk), .peSector(peSector), .statusOne(statusOne),
      .configOne(configOne), .hwProtected(hwProtected),
      .regWriteRejected(regWriteRejected), .resumeReq(resumeReq), .peGrant(peGrant),
      .peDeny(peDeny));
   host_model u_host_model (.sclk(sclk), .csB(csB), .dataIn(dataIn), .wpLevel(wpLevel));

   ////////////////////////////////////////////////////////////////////////////
   // Clock, pulse capture and the hang guard.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Pulses last one cycle, so they are caught here rather than polled.
   always @(posedge clk)
      seen <= seen | {peDeny, peGrant, resumeReq, regWriteRejected};
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         endOfTest();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checkCount++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   // One frame, then room for the decision and the status update.
   task automatic cmd(input logic [23:0] w, input int n, input bit quad);
      u_host_model.send(w, n, quad);
      tick(12);
   endtask
   task automatic pe(input logic [6:0] s, input logic bulk);
      peSector = s;
      peBulk = bulk;
      peReq = 1'b1;
      tick(1);
      peReq = 1'b0;
      peBulk = 1'b0;
      tick(3);
   endtask
   task automatic endOfTest();
      $display("checks %0d mismatches %0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Latch commands, including badly framed and busy cases.
   task automatic testLatch();
      chk(statusOne, 8'h00);
      cmd(OP_SET_LATCH, 8, 1'b0);
      chk(statusOne, 8'h02);
      cmd(OP_CLEAR_LATCH, 8, 1'b0);
      chk(statusOne, 8'h00);
      cmd({OP_SET_LATCH, 1'b0}, 9, 1'b0);
      chk(statusOne, 8'h00);
      // Four-bit mode is entered and left through the config byte.
      cmd(OP_SET_LATCH, 8, 1'b0);
      cmd({OP_REG_WRITE, 8'h00, 8'h02}, 24, 1'b0);
      tick(30);
      chk(configOne, 8'h02);
      cmd(OP_SET_LATCH, 8, 1'b1);
      chk(statusOne, 8'h02);
      cmd(OP_CLEAR_LATCH, 8, 1'b1);
      chk(statusOne, 8'h00);
      cmd(OP_SET_LATCH, 8, 1'b1);
      cmd({OP_REG_WRITE, 8'h00, 8'h00}, 24, 1'b1);
      tick(30);
      chk(configOne, 8'h00);
      chk(statusOne, 8'h00);
      cmd(OP_SET_LATCH, 8, 1'b0);
      chk(statusOne, 8'h02);
      cmd(OP_CLEAR_LATCH >> 1, 7, 1'b0);
      chk(statusOne, 8'h02);
      coreBusy = 1'b1;
      cmd(OP_CLEAR_LATCH, 8, 1'b0);
      chk(statusOne, 8'h03);
      coreBusy = 1'b0;
      tick(4);
      $display("latch test done");
   endtask

   // Fail flags hold busy; both clear codes and the resume reading of 30h.
   task automatic testClear();
      eraseFailSet = 1'b1;
      programFailSet = 1'b1;
      tick(1);
      eraseFailSet = 1'b0;
      programFailSet = 1'b0;
      tick(3);
      chk(statusOne, 8'h63);
      seen = 4'h0;
      cmd(OP_CLEAR_FAIL_LEGACY, 8, 1'b0);
      chk(statusOne, 8'h63);
      chk(seen, 4'h2);
      cmd({OP_CLEAR_FAIL_ALT, 1'b1}, 9, 1'b0);
      chk(statusOne, 8'h63);
      cmd(OP_CLEAR_FAIL_ALT, 8, 1'b0);
      chk(statusOne, 8'h02);
      legacyClearEn = 1'b1;
      eraseFailSet = 1'b1;
      tick(1);
      eraseFailSet = 1'b0;
      cmd(OP_CLEAR_FAIL_LEGACY, 8, 1'b0);
      chk(statusOne, 8'h02);
      $display("clear test done");
   endtask

   // Lock, range and pin together; program checks against the range.
   task automatic testProtect();
      cmd({OP_REG_WRITE, 8'h9C, 8'h04}, 24, 1'b0);
      tick(40);
      chk(statusOne, 8'h9C);
      chk(configOne, 8'h04);
      wpLevel = 1'b0;
      tick(12);
      chk(hwProtected, 1'b1);
      seen = 4'h0;
      cmd(OP_SET_LATCH, 8, 1'b0);
      cmd({OP_REG_WRITE, 8'h00}, 16, 1'b0);
      tick(30);
      chk(statusOne, 8'h9E);
      pe(7'h05, 1'b0);
      chk(seen, 4'h9);
      wpLevel = 1'b1;
      tick(12);
      chk(hwProtected, 1'b0);
      cmd({OP_REG_WRITE, 8'h00}, 16, 1'b0);
      tick(40);
      chk(statusOne, 8'h00);
      chk(configOne, 8'h04);
      seen = 4'h0;
      cmd(OP_SET_LATCH, 8, 1'b0);
      pe(7'h05, 1'b0);
      chk(seen, 4'h4);
      seen = 4'h0;
      pe(7'h00, 1'b1);
      chk(seen, 4'h4);
      $display("protect test done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reset for six cycles, then the scenarios in order.
   initial
   begin
      {legacyClearEn, coreBusy, eraseFailSet, programFailSet, peReq, peBulk} = 6'h00;
      {rst_b, peSector, seen, wpLevel} = {1'b0, 7'h00, 4'h0, 1'b1};
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      tick(6);
      testLatch();
      testClear();
      testProtect();
      endOfTest();
   end
endmodule
